// file: src/fcor_top.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - four 8-bit registers, one loaded from flash at reset, plus 8-byte key
// - ratio register bit 7 read-only; bits 6..0 take only first write
// - loaded flag cleared by reset, set by first ratio write, any data
// - program and erase disabled until loaded flag is set
// - prescale bit selects bus clock divided by 8 as divider input
// - flash clock is divider input over ratio field plus one
// - each timing pulse is one flash clock cycle; whole pulses only
// - option register loaded from stored option byte during reset
// - option bits 5..2 unused, read as zero
// - writes to option register have no effect
// - key-allow bit zero refuses any backdoor key attempt
// - key bytes written from background debug never unlock
// - ordered 8-byte matching firmware key write unlocks until reset
// - option bit 6 set disables vector redirection
// - only security code 1:0 means unsecured
// - secure device blocks memory access from unsecured sources
// - code becomes 1:0 on key match or fully blank check
// - program or erase before ratio write sets access error, ignored
module fcor_top (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire fcor_pkg::fcor_bus_req_t bus_i,
  output logic [fcor_pkg::DATA_W-1:0] rdata_o,
  input wire logic [fcor_pkg::DATA_W-1:0] stored_option_byte_i,
  input wire logic [fcor_pkg::KEY_BYTES*8-1:0] stored_backdoor_key_i,
  input wire logic blank_check_ok_i,
  input wire logic pe_request_i,
  input wire logic access_from_unsecured_i,
  output logic pe_enable_o,
  output logic pe_start_o,
  output logic access_error_o,
  output logic fclk_tick_o,
  output logic secure_o,
  output logic vector_redirect_off_o,
  output logic backdoor_key_allow_o,
  output logic mem_access_ok_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_secure(
    input logic [fcor_pkg::SEC_W-1:0] code
  );
    is_secure = (code != fcor_pkg::SEC_UNSECURED);
  endfunction

  function automatic logic [7:0] key_byte(
    input logic [fcor_pkg::KEY_BYTES*8-1:0] key,
    input logic [2:0] idx
  );
    key_byte = key[{idx, 3'h0} +: 8];
  endfunction

  fcor_pkg::fcor_state_t s;
  fcor_pkg::fcor_state_t next_s;

  logic wr_ratio;
  logic wr_keyctl;
  logic wr_status;
  logic wr_key;
  logic pre_step;
  logic new_acc;
  logic [2:0] key_idx;

  assign key_idx = bus_i.addr[2:0];
  assign wr_ratio = bus_i.wr && (bus_i.addr == fcor_pkg::OFS_RATIO);
  assign wr_keyctl = bus_i.wr && (bus_i.addr == fcor_pkg::OFS_KEYCTL);
  assign wr_status = bus_i.wr && (bus_i.addr == fcor_pkg::OFS_STATUS);
  assign wr_key = bus_i.wr && bus_i.addr[fcor_pkg::KEY_SEL_BIT];
  assign new_acc = bus_i.wdata[fcor_pkg::KEYCTL_ACC_BIT];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.fclk_tick = 1'b0;
    next_s.pe_start = 1'b0;
    next_s.rdata = '0;
    pre_step = 1'b0;

    // write-once divider; flag set whatever the data
    if (wr_ratio && !s.ratio_loaded)
    begin
      next_s.ratio_loaded = 1'b1;
      next_s.prescale_by_eight = bus_i.wdata[fcor_pkg::PRESCALE_BIT];
      next_s.ratio = bus_i.wdata[fcor_pkg::DIV_W-1:0];
    end

    // flash clock: tick lasts one bus cycle per flash clock period
    // ratio zero without prescale leaves the tick high every cycle
    if (s.ratio_loaded)
    begin
      pre_step = !s.prescale_by_eight ||
                 (s.pre_cnt == fcor_pkg::PRESCALE_LAST);
      if (s.prescale_by_eight)
      begin
        next_s.pre_cnt = s.pre_cnt + 3'h1;
      end
      if (pre_step)
      begin
        if (s.div_cnt == s.ratio)
        begin
          next_s.div_cnt = '0;
          next_s.fclk_tick = 1'b1;
        end
        else
        begin
          next_s.div_cnt = s.div_cnt + 6'h01;
        end
      end
    end

    // key entry window
    if (wr_keyctl)
    begin
      next_s.key_access = new_acc;
      if (new_acc && !s.key_access)
      begin
        next_s.key_cnt = '0;
        next_s.key_bad = 1'b0;
      end
      if (!new_acc && s.key_access && s.backdoor_key_allow && !s.key_bad &&
          (s.key_cnt == fcor_pkg::KEY_CNT_FULL))
      begin
        next_s.security_state_code = fcor_pkg::SEC_UNSECURED;
      end
    end

    // any debug, out-of-order, surplus or wrong byte spoils the attempt
    if (wr_key && s.key_access)
    begin
      if (bus_i.from_debug || !s.backdoor_key_allow ||
          (s.key_cnt == fcor_pkg::KEY_CNT_FULL) ||
          ({1'b0, key_idx} != s.key_cnt) ||
          (bus_i.wdata != key_byte(stored_backdoor_key_i, key_idx)))
      begin
        next_s.key_bad = 1'b1;
      end
      else
      begin
        next_s.key_cnt = s.key_cnt + 4'h1;
      end
    end

    if (blank_check_ok_i)
    begin
      next_s.security_state_code = fcor_pkg::SEC_UNSECURED;
    end

    // clear first so a same-cycle error still lands
    if (wr_status && bus_i.wdata[fcor_pkg::STAT_ERR_BIT])
    begin
      next_s.access_error_flag = 1'b0;
    end
    if (pe_request_i)
    begin
      if (!s.ratio_loaded)
      begin
        next_s.access_error_flag = 1'b1;
      end
      else
      begin
        next_s.pe_start = 1'b1;
      end
    end

    // option register has no write path at all
    if (bus_i.rd)
    begin
      case (bus_i.addr)
        fcor_pkg::OFS_RATIO:
        begin
          next_s.rdata = {s.ratio_loaded, s.prescale_by_eight, s.ratio};
        end
        fcor_pkg::OFS_OPTION:
        begin
          next_s.rdata = {s.backdoor_key_allow, s.vector_redirect_off,
                          4'h0, s.security_state_code};
        end
        fcor_pkg::OFS_KEYCTL:
        begin
          next_s.rdata[fcor_pkg::KEYCTL_ACC_BIT] = s.key_access;
        end
        fcor_pkg::OFS_STATUS:
        begin
          next_s.rdata[fcor_pkg::STAT_ERR_BIT] = s.access_error_flag;
          next_s.rdata[fcor_pkg::STAT_SECURE_BIT] =
            is_secure(s.security_state_code);
          next_s.rdata[fcor_pkg::STAT_PE_EN_BIT] = s.ratio_loaded;
        end
        default:
        begin
          next_s.rdata = '0;
        end
      endcase
    end

    // synchronous reset copies the stored option byte
    // the stored byte is read only while reset is low, never later
    if (!resetn_i)
    begin
      next_s = '0;
      next_s.backdoor_key_allow =
        stored_option_byte_i[fcor_pkg::OPT_KEY_ALLOW_BIT];
      next_s.vector_redirect_off =
        stored_option_byte_i[fcor_pkg::OPT_REDIR_OFF_BIT];
      next_s.security_state_code =
        stored_option_byte_i[fcor_pkg::SEC_W-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = s.rdata;
  assign pe_enable_o = s.ratio_loaded;
  assign pe_start_o = s.pe_start;
  assign access_error_o = s.access_error_flag;
  assign fclk_tick_o = s.fclk_tick;
  assign secure_o = is_secure(s.security_state_code);
  assign vector_redirect_off_o = s.vector_redirect_off;
  assign backdoor_key_allow_o = s.backdoor_key_allow;
  // gate only, no stall: a blocked read returns zero upstream
  assign mem_access_ok_o = !secure_o || !access_from_unsecured_i;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_loaded_sticky: assert property (
    s.ratio_loaded |=> s.ratio_loaded)
    else $error("ratio loaded flag dropped");

  a_ratio_once: assert property (
    s.ratio_loaded |=> $stable({s.prescale_by_eight, s.ratio}))
    else $error("ratio field changed after first write");

  a_first_write: assert property (
    (wr_ratio && !s.ratio_loaded)
      |=> s.ratio_loaded &&
          s.ratio == $past(bus_i.wdata[fcor_pkg::DIV_W-1:0]))
    else $error("first ratio write not taken");

  a_pe_blocked: assert property (
    (pe_request_i && !pe_enable_o) |=> access_error_o && !pe_start_o)
    else $error("early program request not refused");

  a_pe_started: assert property (
    pe_start_o |-> $past(pe_request_i) && $past(pe_enable_o))
    else $error("program start without enable");

  a_tick_div1: assert property (
    (fclk_tick_o && !s.prescale_by_eight && s.ratio == 6'h01)
      |=> !fclk_tick_o ##1 fclk_tick_o)
    else $error("flash clock period wrong for ratio one");

  a_tick_pre8: assert property (
    (fclk_tick_o && s.prescale_by_eight && s.ratio == 6'h00)
      |=> !fclk_tick_o [*7] ##1 fclk_tick_o)
    else $error("prescaled flash clock period wrong");

  a_option_fixed: assert property (
    $stable({s.backdoor_key_allow, s.vector_redirect_off}))
    else $error("option bits changed outside reset");

  a_option_pad: assert property (
    (bus_i.rd && bus_i.addr == fcor_pkg::OFS_OPTION) |=> rdata_o[5:2] == 4'h0)
    else $error("unused option bits not zero");

  a_debug_key: assert property (
    (wr_key && s.key_access && bus_i.from_debug) |=> s.key_bad)
    else $error("debug key write not spoiled");

  a_no_key_unlock: assert property (
    (secure_o && !s.backdoor_key_allow && !blank_check_ok_i) |=> secure_o)
    else $error("unlocked with key disabled");

  a_blank_unlock: assert property (
    blank_check_ok_i |=> !secure_o)
    else $error("blank check did not unsecure");

  a_mem_block: assert property (
    (secure_o && access_from_unsecured_i) |-> !mem_access_ok_o)
    else $error("secure memory reachable from unsecured source");

  // ----------------------------------------------------------------
  // divider and register read-back checks beyond the two fixed-period cases
  // ----------------------------------------------------------------
  a_tick_gap_pre8: assert property (
    (fclk_tick_o && s.prescale_by_eight) |=> !fclk_tick_o [*7])
    else $error("prescaled flash clock ticks too close");

  a_tick_unloaded: assert property (
    !pe_enable_o |=> !fclk_tick_o)
    else $error("flash clock running before ratio load");

  a_ratio_read: assert property (
    (bus_i.rd && bus_i.addr == fcor_pkg::OFS_RATIO)
      |=> rdata_o == {$past(pe_enable_o), $past(s.prescale_by_eight),
                      $past(s.ratio)})
    else $error("ratio register read back wrong");

  a_option_read: assert property (
    (bus_i.rd && bus_i.addr == fcor_pkg::OFS_OPTION)
      |=> rdata_o == {$past(backdoor_key_allow_o),
                      $past(vector_redirect_off_o), 4'h0,
                      $past(s.security_state_code)})
    else $error("option register read back wrong");

  // ----------------------------------------------------------------
  // error flag and register bus
  // ----------------------------------------------------------------
  a_err_sticky: assert property (
    (access_error_o &&
     !(wr_status && bus_i.wdata[fcor_pkg::STAT_ERR_BIT]))
      |=> access_error_o)
    else $error("access error flag dropped without clear");

  a_err_clear: assert property (
    (wr_status && bus_i.wdata[fcor_pkg::STAT_ERR_BIT] && !pe_request_i)
      |=> !access_error_o)
    else $error("access error flag not cleared");

  a_status_read: assert property (
    (bus_i.rd && bus_i.addr == fcor_pkg::OFS_STATUS)
      |=> rdata_o[fcor_pkg::STAT_ERR_BIT] == $past(access_error_o) &&
          rdata_o[fcor_pkg::STAT_SECURE_BIT] == $past(secure_o))
    else $error("status register read back wrong");

  a_read_idle: assert property (
    !bus_i.rd |=> rdata_o == '0)
    else $error("read data held past its cycle");

  // ----------------------------------------------------------------
  // key entry and security
  // ----------------------------------------------------------------
  a_key_refused: assert property (
    (wr_key && s.key_access && !s.backdoor_key_allow) |=> s.key_bad)
    else $error("key byte taken with key access disallowed");

  a_key_unlock: assert property (
    (wr_keyctl && !new_acc && s.key_access && s.backdoor_key_allow &&
     !s.key_bad && s.key_cnt == fcor_pkg::KEY_CNT_FULL) |=> !secure_o)
    else $error("matching key did not unsecure");

  a_unsecure_kept: assert property (
    !secure_o |=> !secure_o)
    else $error("security came back before reset");

  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_tick: cover property (fclk_tick_o ##[1:64] fclk_tick_o);
  c_key_unlock: cover property ($fell(secure_o) && !$past(blank_check_ok_i));
  c_early_pe: cover property (pe_request_i && !pe_enable_o);
  c_pe_start: cover property (pe_start_o);
  c_blank_unlock: cover property (blank_check_ok_i && secure_o);

endmodule

`default_nettype wire

// file: src/fcor_pkg.sv
package fcor_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_RATIO = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OPTION = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_KEYCTL = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;
  // key bytes sit at 0x8..0xf, byte index in the low three bits
  localparam int KEY_SEL_BIT = 3;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int RATIO_LOADED_BIT = 7;
  localparam int PRESCALE_BIT = 6;
  localparam int DIV_W = 6;
  localparam int OPT_KEY_ALLOW_BIT = 7;
  localparam int OPT_REDIR_OFF_BIT = 6;
  localparam int SEC_W = 2;
  localparam int KEYCTL_ACC_BIT = 5;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_SECURE_BIT = 1;
  localparam int STAT_PE_EN_BIT = 2;

  localparam logic [SEC_W-1:0] SEC_UNSECURED = 2'h2;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int PRE_W = 3;
  localparam logic [PRE_W-1:0] PRESCALE_LAST = 3'h7;
  localparam int KEY_BYTES = 8;
  localparam int KEY_CNT_W = 4;
  localparam logic [KEY_CNT_W-1:0] KEY_CNT_FULL = 4'h8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic from_debug;
  } fcor_bus_req_t;

  typedef struct packed {
    logic ratio_loaded;
    logic prescale_by_eight;
    logic [DIV_W-1:0] ratio;
    logic backdoor_key_allow;
    logic vector_redirect_off;
    logic [SEC_W-1:0] security_state_code;
    logic key_access;
    logic [KEY_CNT_W-1:0] key_cnt;
    logic key_bad;
    logic access_error_flag;
    logic [PRE_W-1:0] pre_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic fclk_tick;
    logic pe_start;
    logic [DATA_W-1:0] rdata;
  } fcor_state_t;

endpackage

// file: testbench/test_fcor_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
  end

module test_fcor_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam logic [63:0] KEY = 64'h5a3c_9617_e4d2_0b88;
  logic clk, resetn, blank, pe_req, unsec, dbg;
  fcor_pkg::fcor_bus_req_t bus;
  logic [7:0] rdata, opt, d;
  logic pe_en, pe_start, err, tick, sec, redir, allow, mem_ok;
  int fail_count;
  int samples_checked;

  fcor_top fcor_top_inst (
    .clk_i(clk),
    .resetn_i(resetn),
    .bus_i(bus),
    .rdata_o(rdata),
    .stored_option_byte_i(opt),
    .stored_backdoor_key_i(KEY),
    .blank_check_ok_i(blank),
    .pe_request_i(pe_req),
    .access_from_unsecured_i(unsec),
    .pe_enable_o(pe_en),
    .pe_start_o(pe_start),
    .access_error_o(err),
    .fclk_tick_o(tick),
    .secure_o(sec),
    .vector_redirect_off_o(redir),
    .backdoor_key_allow_o(allow),
    .mem_access_ok_o(mem_ok)
  );

  // ----------------------------------------
  // bus and pin tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.from_debug <= dbg;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // one-cycle pulse on blank check or program/erase request
  task automatic kick(input logic is_blank);
    @(posedge clk);
    if (is_blank)
      blank <= 1'b1;
    else
      pe_req <= 1'b1;
    @(posedge clk);
    blank <= 1'b0;
    pe_req <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic [7:0] o);
    @(posedge clk);
    opt <= o;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_codes;
    for (int c = 0; c < 4; c++)
    begin
      do_reset({2'b10, 4'hf, 2'(c)});
      `CHK("secure", (c != 2), sec)
      `CHK("allow", 1'b1, allow)
      `CHK("redir off", 1'b0, redir)
      rd(fcor_pkg::OFS_OPTION, d);
      `CHK("option", {2'b10, 4'h0, 2'(c)}, d)
    end
  endtask

  task automatic t_early;
    @(posedge clk);
    unsec <= 1'b1;
    #1;
    `CHK("mem ok", 1'b0, mem_ok)
    @(posedge clk);
    unsec <= 1'b0;
    #1;
    `CHK("mem ok free", 1'b1, mem_ok)
    `CHK("pe enable", 1'b0, pe_en)
    rd(fcor_pkg::OFS_RATIO, d);
    `CHK("ratio at reset", 8'h00, d)
    kick(1'b0);
    `CHK("error", 1'b1, err)
    `CHK("start", 1'b0, pe_start)
    rd(fcor_pkg::OFS_STATUS, d);
    `CHK("status", 3'b011, d[2:0])
    wr(fcor_pkg::OFS_STATUS, 8'h01);
    @(posedge clk);
    #1;
    `CHK("error cleared", 1'b0, err)
    rd(4'h5, d);
    `CHK("unmapped", 8'h00, d)
  endtask

  // period in bus cycles between two flash clock ticks
  task automatic t_ratio(input logic pre, input logic [5:0] div);
    int n;
    wr(fcor_pkg::OFS_RATIO, {1'b0, pre, div});
    rd(fcor_pkg::OFS_RATIO, d);
    `CHK("ratio", {1'b1, pre, div}, d)
    `CHK("pe enable", 1'b1, pe_en)
    wr(fcor_pkg::OFS_RATIO, {1'b0, ~pre, ~div});
    wr(fcor_pkg::OFS_OPTION, ~opt);
    rd(fcor_pkg::OFS_OPTION, d);
    `CHK("option kept", {opt[7:6], 4'h0, opt[1:0]}, d)
    rd(fcor_pkg::OFS_RATIO, d);
    `CHK("ratio kept", {1'b1, pre, div}, d)
    n = 0;
    while (tick !== 1'b1 && n < 600)
    begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (tick !== 1'b1 && n < 600);
    `CHK("tick period", (int'(div) + 1) * (pre ? 8 : 1), n)
    kick(1'b0);
    `CHK("start", 1'b1, pe_start)
    `CHK("no error", 1'b0, err)
  endtask

  task automatic key_try(input logic dg, input logic [7:0] x,
                         input logic exp);
    wr(fcor_pkg::OFS_KEYCTL, 8'h20);
    rd(fcor_pkg::OFS_KEYCTL, d);
    `CHK("key access", 8'h20, d)
    dbg = dg;
    for (int i = 0; i < 8; i++)
      wr(4'h8 + 4'(i), KEY[8*i +: 8] ^ (i == 3 ? x : 8'h00));
    dbg = 1'b0;
    wr(fcor_pkg::OFS_KEYCTL, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK("secure after key", exp, sec)
  endtask

  task automatic t_key;
    do_reset(8'h83);
    rd(4'h9, d);
    `CHK("key byte read", 8'h00, d)
    key_try(1'b1, 8'h00, 1'b1);
    key_try(1'b0, 8'h10, 1'b1);
    key_try(1'b0, 8'h00, 1'b0);
    do_reset(8'h03);
    key_try(1'b0, 8'h00, 1'b1);
    kick(1'b1);
    `CHK("blank unsecures", 1'b0, sec)
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // whole run is under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    resetn = 1'b0;
    bus = '0;
    opt = 8'h83;
    blank = 1'b0;
    pe_req = 1'b0;
    unsec = 1'b0;
    dbg = 1'b0;
    t_codes();
    do_reset(8'h83);
    t_early();
    t_ratio(1'b1, 6'h00);
    do_reset(8'h42);
    `CHK("redir off", 1'b1, redir)
    t_ratio(1'b0, 6'h01);
    // 40 MHz bus clock / 8 / 25 puts the flash clock on 200 kHz
    do_reset(8'h83);
    t_ratio(1'b1, 6'h18);
    t_key();
    conclude();
  end
endmodule

`default_nettype wire
